// file: core/conv_ctl_pkg.sv
package conv_ctl_pkg;

   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [7:0] STATUS_OFFSET = 8'h00;
   localparam logic [7:0] CONTROL_ZERO_OFFSET = 8'h04;
   localparam logic [7:0] ROUTINE_DATA_OFFSET = 8'h4C;
   localparam logic [31:0] CONTROL_ZERO_RESET = 32'h0000_0000;
   localparam logic [31:0] CONTROL_ZERO_WRITABLE = 32'h008F_EB7F;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

   // ****************************************************
   // Control register zero fields
   // ****************************************************
   localparam int ROUTINE_WATCHDOG_ENABLE_BIT = 23;
   localparam int SYNC_MODE_LSB = 16;
   localparam int SYNC_MODE_MSB = 19;
   localparam int DISC_COUNT_LSB = 13;
   localparam int DISC_COUNT_MSB = 15;
   localparam int ROUTINE_DISC_ENABLE_BIT = 11;
   localparam int WATCHDOG_SINGLE_CHANNEL_BIT = 9;
   localparam int SCAN_ENABLE_BIT = 8;
   localparam int WATCHDOG_IRQ_ENABLE_BIT = 6;
   localparam int CONVERSION_DONE_IRQ_ENABLE_BIT = 5;
   localparam int WATCHDOG_CHANNEL_LSB = 0;
   localparam int WATCHDOG_CHANNEL_MSB = 4;

   // ****************************************************
   // Status fields
   // ****************************************************
   localparam int WATCHDOG_EVENT_FLAG_BIT = 0;
   localparam int CONVERSION_DONE_FLAG_BIT = 1;

   // ****************************************************
   // Channels and codes
   // ****************************************************
   localparam logic [4:0] LAST_CHANNEL = 5'h11;
   localparam logic [4:0] INTERNAL_CHANNEL_LOW = 5'h10;
   localparam int DATA_WIDTH = 16;

   typedef enum logic [3:0] {
      SYNC_INDEPENDENT = 4'b0000,
      SYNC_ROUTINE_PARALLEL = 4'b0110,
      SYNC_FOLLOW_UP_FAST = 4'b0111,
      SYNC_FOLLOW_UP_SLOW = 4'b1000
   } sync_mode_t;

   typedef enum logic [1:0] {
      SRC_EXTERNAL_PIN = 2'b00,
      SRC_TEMPERATURE = 2'b01,
      SRC_INTERNAL_REFERENCE = 2'b10,
      SRC_ANALOG_GROUND = 2'b11
   } channel_source_t;

   typedef enum logic [1:0] {
      BURST_IDLE = 2'b00,
      BURST_RUN = 2'b01,
      BURST_HOLD = 2'b10
   } burst_state_t;

   // One finished conversion from the converter core
   typedef struct packed {
      logic valid;
      logic [4:0] channel;
      logic out_of_window;
      logic sequence_end;
      logic [DATA_WIDTH-1:0] data;
   } sample_t;

   // Control fields steering the sequencer
   typedef struct packed {
      logic scan_enable;
      logic discontinuous_enable;
      logic [3:0] burst_length;
      sync_mode_t sync_mode;
   } sequencer_ctl_t;

endpackage : conv_ctl_pkg

// file: core/conv_ctl_zero.sv
// Functional notes
// - bit 23 enables routine watchdog checking
// - bits 19:16 select sync mode codes
// - sync mode acts only in first converter
// - each trigger converts count plus one channels
// - bit 11 selects discontinuous routine sequencing
// - bit 9 limits watchdog to selected channel while bit 8 scanning is set
// - bit 8 enables scanning the channel sequence
// - bit 6 gates watchdog interrupt
// - bit 5 gates conversion done interrupt
// - bits 4:0 select watchdog channel 0..17
// - channels 16,17 internal; ground off first
// - register at 0x04, resets to zero
// - watchdog flag status bit 0, write-zero clears
// - done flag bit 1, write-zero or data read clears
module conv_ctl_zero #(
   parameter bit FIRST_INSTANCE = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire conv_ctl_pkg::sample_t sample,
   input wire logic trigger,
   output conv_ctl_pkg::sequencer_ctl_t seq_ctl,
   output logic seq_hold,
   output conv_ctl_pkg::channel_source_t ch16_source,
   output conv_ctl_pkg::channel_source_t ch17_source,
   output logic irq
);

   // ****************************************************
   // Bus decode
   // ****************************************************
   logic [31:0] ctl_q;
   logic [31:0] ctl_d;
   logic wd_flag_q;
   logic wd_flag_d;
   logic done_flag_q;
   logic done_flag_d;
   logic [conv_ctl_pkg::DATA_WIDTH-1:0] data_q;
   conv_ctl_pkg::burst_state_t burst_q;
   conv_ctl_pkg::burst_state_t burst_d;
   logic [3:0] burst_cnt_q;
   logic [3:0] burst_cnt_d;

   wire logic [7:0] offset = paddr[7:0];
   wire logic upper_zero = (paddr[31:8] == 24'h00_0000);
   wire logic hit_status = upper_zero && (offset == conv_ctl_pkg::STATUS_OFFSET);
   wire logic hit_ctl = upper_zero && (offset == conv_ctl_pkg::CONTROL_ZERO_OFFSET);
   wire logic hit_data = upper_zero && (offset == conv_ctl_pkg::ROUTINE_DATA_OFFSET);
   wire logic mapped = hit_status || hit_ctl || hit_data;
   wire logic access = psel && penable;
   wire logic wr_status = access && pwrite && hit_status;
   wire logic wr_ctl = access && pwrite && hit_ctl;
   wire logic rd_data = access && !pwrite && hit_data;

   // Zero wait state slave, error on unmapped offsets
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // Read mux
   wire logic [31:0] status_word = {30'h0000_0000, done_flag_q, wd_flag_q};
   wire logic [31:0] data_word = {{(32 - conv_ctl_pkg::DATA_WIDTH){1'b0}}, data_q};
   assign prdata = hit_status ? status_word :
                   hit_ctl ? ctl_q :
                   hit_data ? data_word : 32'h0000_0000;

   // ****************************************************
   // Control field extraction
   // ****************************************************
   wire logic wd_enable = ctl_q[conv_ctl_pkg::ROUTINE_WATCHDOG_ENABLE_BIT];
   wire logic [3:0] sync_field =
      ctl_q[conv_ctl_pkg::SYNC_MODE_MSB:conv_ctl_pkg::SYNC_MODE_LSB];
   wire logic [2:0] disc_count =
      ctl_q[conv_ctl_pkg::DISC_COUNT_MSB:conv_ctl_pkg::DISC_COUNT_LSB];
   wire logic disc_enable = ctl_q[conv_ctl_pkg::ROUTINE_DISC_ENABLE_BIT];
   wire logic wd_single = ctl_q[conv_ctl_pkg::WATCHDOG_SINGLE_CHANNEL_BIT];
   wire logic scan_enable = ctl_q[conv_ctl_pkg::SCAN_ENABLE_BIT];
   wire logic wd_irq_en = ctl_q[conv_ctl_pkg::WATCHDOG_IRQ_ENABLE_BIT];
   wire logic done_irq_en = ctl_q[conv_ctl_pkg::CONVERSION_DONE_IRQ_ENABLE_BIT];
   wire logic [4:0] wd_channel =
      ctl_q[conv_ctl_pkg::WATCHDOG_CHANNEL_MSB:conv_ctl_pkg::WATCHDOG_CHANNEL_LSB];

   // Reserved codes fall back to independent operation
   logic sync_known;
   assign sync_known = (sync_field == conv_ctl_pkg::SYNC_INDEPENDENT)
                    || (sync_field == conv_ctl_pkg::SYNC_ROUTINE_PARALLEL)
                    || (sync_field == conv_ctl_pkg::SYNC_FOLLOW_UP_FAST)
                    || (sync_field == conv_ctl_pkg::SYNC_FOLLOW_UP_SLOW);
   wire logic sync_active = FIRST_INSTANCE && sync_known;

   // Burst length is count plus one
   wire logic [3:0] burst_len = {1'b0, disc_count} + 4'h1;

   // Sequencer steering outputs
   assign seq_ctl.scan_enable = scan_enable;
   assign seq_ctl.discontinuous_enable = disc_enable;
   assign seq_ctl.burst_length = burst_len;
   assign seq_ctl.sync_mode = sync_active ? conv_ctl_pkg::sync_mode_t'(sync_field)
                                          : conv_ctl_pkg::SYNC_INDEPENDENT;

   // Internal inputs on the two top channels
   assign ch16_source = FIRST_INSTANCE ? conv_ctl_pkg::SRC_TEMPERATURE
                                       : conv_ctl_pkg::SRC_ANALOG_GROUND;
   assign ch17_source = FIRST_INSTANCE ? conv_ctl_pkg::SRC_INTERNAL_REFERENCE
                                       : conv_ctl_pkg::SRC_ANALOG_GROUND;

   // ****************************************************
   // Watchdog check
   // ****************************************************
   wire logic wd_channel_legal = (wd_channel <= conv_ctl_pkg::LAST_CHANNEL);
   wire logic wd_channel_match = wd_channel_legal && (sample.channel == wd_channel);
   // Single channel selection applies while scanning
   wire logic wd_in_scope = !(scan_enable && wd_single) || wd_channel_match;
   wire logic wd_event = sample.valid && sample.out_of_window
                      && wd_enable && wd_in_scope;
   wire logic done_event = sample.valid && sample.sequence_end;

   // ****************************************************
   // Register next values
   // ****************************************************
   // Reserved bits never store
   assign ctl_d = wr_ctl ? (pwdata & conv_ctl_pkg::CONTROL_ZERO_WRITABLE) : ctl_q;

   // Set wins over a clear in the same cycle
   wire logic wd_clear = wr_status && !pwdata[conv_ctl_pkg::WATCHDOG_EVENT_FLAG_BIT];
   wire logic done_clear = (wr_status && !pwdata[conv_ctl_pkg::CONVERSION_DONE_FLAG_BIT])
                        || rd_data;
   assign wd_flag_d = wd_event || (wd_flag_q && !wd_clear);
   assign done_flag_d = done_event || (done_flag_q && !done_clear);

   // Interrupt request from enabled flags
   assign irq = (wd_flag_q && wd_irq_en)
             || (done_flag_q && done_irq_en);

   // ****************************************************
   // Discontinuous burst counter
   // ****************************************************
   always_comb begin
      burst_d = burst_q;
      burst_cnt_d = burst_cnt_q;
      case (burst_q)
         conv_ctl_pkg::BURST_IDLE: begin
            if (trigger && disc_enable) begin
               burst_d = conv_ctl_pkg::BURST_RUN;
               burst_cnt_d = 4'h0;
            end
         end
         conv_ctl_pkg::BURST_RUN: begin
            if (!disc_enable) begin
               burst_d = conv_ctl_pkg::BURST_IDLE;
            end else if (sample.valid) begin
               burst_cnt_d = burst_cnt_q + 4'h1;
               if ((burst_cnt_q + 4'h1) >= burst_len) begin
                  burst_d = conv_ctl_pkg::BURST_HOLD;
               end
            end
         end
         conv_ctl_pkg::BURST_HOLD: begin
            if (!disc_enable) begin
               burst_d = conv_ctl_pkg::BURST_IDLE;
            end else if (trigger) begin
               burst_d = conv_ctl_pkg::BURST_RUN;
               burst_cnt_d = 4'h0;
            end
         end
         default: begin
            burst_d = conv_ctl_pkg::BURST_IDLE;
         end
      endcase
   end

   // Sequencer pauses between bursts
   assign seq_hold = disc_enable && (burst_q != conv_ctl_pkg::BURST_RUN);

   // ****************************************************
   // Flip-flops
   // ****************************************************
   // Control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= conv_ctl_pkg::CONTROL_ZERO_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // Status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_flag_q <= conv_ctl_pkg::STATUS_RESET[conv_ctl_pkg::WATCHDOG_EVENT_FLAG_BIT];
         done_flag_q <= conv_ctl_pkg::STATUS_RESET[conv_ctl_pkg::CONVERSION_DONE_FLAG_BIT];
      end else begin
         wd_flag_q <= wd_flag_d;
         done_flag_q <= done_flag_d;
      end
   end

   // Routine data capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_q <= '0;
      end else if (sample.valid) begin
         data_q <= sample.data;
      end
   end

   // Burst state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_q <= conv_ctl_pkg::BURST_IDLE;
         burst_cnt_q <= 4'h0;
      end else begin
         burst_q <= burst_d;
         burst_cnt_q <= burst_cnt_d;
      end
   end

endmodule : conv_ctl_zero

// file: dv/conv_ctl_zero_monitor.sv
module conv_ctl_zero_monitor #(
   parameter bit FIRST_INSTANCE = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire conv_ctl_pkg::sample_t sample,
   input wire conv_ctl_pkg::sequencer_ctl_t seq_ctl,
   input wire logic seq_hold,
   input wire conv_ctl_pkg::channel_source_t ch16_source,
   input wire conv_ctl_pkg::channel_source_t ch17_source,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************
   // Shadow of the control word
   // ****************************************************
   logic [31:0] ctl_q;
   wire ctl_wr = psel && penable && pwrite && paddr[7:0] == conv_ctl_pkg::CONTROL_ZERO_OFFSET;
   wire ctl_rd = psel && penable && !pwrite && paddr[7:0] == conv_ctl_pkg::CONTROL_ZERO_OFFSET;
   // Reserved channel codes never match in single channel mode
   wire sel_ok = !(ctl_q[8] && ctl_q[9])
      || (sample.channel == ctl_q[4:0] && ctl_q[4:0] <= 5'h11);
   wire wd_hit = sample.valid && sample.out_of_window && ctl_q[23] && ctl_q[6] && sel_ok;
   wire done_hit = sample.valid && sample.sequence_end && ctl_q[5];
   wire mapped = paddr[7:0] inside {8'h00, 8'h04, 8'h4C};
   wire logic [1:0] src16 = FIRST_INSTANCE ? 2'h1 : 2'h3;
   wire logic [1:0] src17 = FIRST_INSTANCE ? 2'h2 : 2'h3;

   // Tracks writes with reserved bits dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 32'h0000_0000;
      end else if (ctl_wr) begin
         ctl_q <= pwdata & conv_ctl_pkg::CONTROL_ZERO_WRITABLE;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence ctl_write_s;
      ctl_wr;
   endsequence
   sequence sync_write_s;
      ctl_write_s ##0 (pwdata[19:16] inside {4'h0, 4'h6, 4'h7, 4'h8});
   endsequence

   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   a_unmapped_err: assert property (psel && penable && !mapped |->
      pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_ctl_readback: assert property (ctl_rd |-> prdata == ctl_q && !pslverr)
      else $error("control read differs from written value");
   a_field_drive: assert property (ctl_write_s |=>
      seq_ctl.scan_enable == $past(pwdata[8])
      && seq_ctl.discontinuous_enable == $past(pwdata[11])
      && seq_ctl.burst_length == {1'b0, $past(pwdata[15:13])} + 4'h1)
      else $error("sequencer fields do not follow control write");
   a_sync_drive: assert property (sync_write_s |=>
      seq_ctl.sync_mode == (FIRST_INSTANCE ? $past(pwdata[19:16]) : 4'h0))
      else $error("sync mode output wrong");
   a_wd_irq: assert property (wd_hit && !ctl_wr |=> irq)
      else $error("watchdog event gave no interrupt");
   a_done_irq: assert property (done_hit && !ctl_wr |=> irq)
      else $error("sequence end gave no interrupt");
   a_irq_gated: assert property (irq |-> ctl_q[6] || ctl_q[5])
      else $error("interrupt with both enables clear");
   a_hold_disc: assert property (seq_hold |-> ctl_q[11])
      else $error("hold while discontinuous mode off");
   a_internal_src: assert property (ch16_source == src16 && ch17_source == src17)
      else $error("internal channel source wrong");
endmodule : conv_ctl_zero_monitor

bind conv_ctl_zero conv_ctl_zero_monitor #(.FIRST_INSTANCE(FIRST_INSTANCE))
   i_conv_ctl_zero_monitor (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .sample, .seq_ctl, .seq_hold, .ch16_source, .ch17_source, .irq);

// file: dv/test_adc_control_register_zero.sv
module test_adc_control_register_zero;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, trigger, pready, pslverr, irq, seq_hold, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   conv_ctl_pkg::sample_t sample;
   conv_ctl_pkg::sequencer_ctl_t seq_ctl;
   conv_ctl_pkg::channel_source_t ch16_source, ch17_source;
   int bad_count = 0;
   int total_checks = 0;

   conv_ctl_zero i_conv_ctl_zero (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sample, .trigger, .seq_ctl, .seq_hold, .ch16_source,
      .ch17_source, .irq);

   // ****************************************************
   // Shared tasks
   // ****************************************************
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic wrap_up;
      if (bad_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask : check

   // One APB transfer, answer taken at the ready edge, ends at a falling edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {24'h00_0000, a};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            bad_count++;
            wrap_up();
         end
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask : apb

   // One converted sample, ends at a falling edge
   task automatic send(input logic [4:0] ch, input logic oow, input logic last);
      @(posedge pclk);
      sample <= {1'b1, ch, oow, last, 16'h1234};
      @(posedge pclk);
      sample <= '0;
      @(negedge pclk);
   endtask : send

   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_reset;
      apb(1'b0, 8'h04, 32'h0);
      check("ctl_reset", 32'h0000_0000, rd);
      check("sources", 32'h0000_0009, {28'h0, ch17_source, ch16_source});
      apb(1'b0, 8'h08, 32'h0);
      check("unmapped_err", 32'h0000_0001, {31'h0, er});
      apb(1'b1, 8'h08, 32'hFFFF_FFFF);
      apb(1'b0, 8'h04, 32'h0);
      check("ctl_untouched", 32'h0000_0000, rd);
   endtask : t_reset

   task automatic t_fields;
      logic [3:0] codes [4] = '{4'h0, 4'h6, 4'h7, 4'h8};
      logic [31:0] w;
      apb(1'b1, 8'h04, 32'h008F_EB7F);
      apb(1'b0, 8'h04, 32'h0);
      check("ctl_mask", 32'h008F_EB7F, rd);
      for (int i = 0; i < 4; i++) begin
         w = {12'h0, 4'h0, 3'(2 * i + 1), 1'b0, ~i[0], 2'b0, i[0], 8'h0};
         apb(1'b1, 8'h04, 32'h0);
         apb(1'b1, 8'h04, w);
         w[19:16] = codes[i];
         apb(1'b1, 8'h04, w);
         check("seq_ctl", {22'h0, i[0], ~i[0], 4'(2 * i + 2), codes[i]}, 32'(seq_ctl));
      end
      apb(1'b1, 8'h04, 32'h0);
   endtask : t_fields

   task automatic t_watchdog;
      apb(1'b1, 8'h04, 32'h0080_0351);
      send(5'h05, 1'b1, 1'b0);
      check("irq_other_ch", 32'h0, 32'(irq));
      send(5'h11, 1'b1, 1'b0);
      check("irq_sel_ch", 32'h1, 32'(irq));
      apb(1'b0, 8'h00, 32'h0);
      check("status_wd", 32'h1, rd);
      apb(1'b1, 8'h00, 32'h0);
      check("irq_cleared", 32'h0, 32'(irq));
      apb(1'b1, 8'h04, 32'h0000_0040);
      send(5'h11, 1'b1, 1'b0);
      check("irq_wd_off", 32'h0, 32'(irq));
      apb(1'b1, 8'h04, 32'h0080_0000);
      send(5'h03, 1'b1, 1'b0);
      check("irq_masked", 32'h0, 32'(irq));
      apb(1'b1, 8'h04, 32'h0080_0040);
      check("irq_unmasked", 32'h1, 32'(irq));
      apb(1'b1, 8'h00, 32'h0);
   endtask : t_watchdog

   task automatic t_done;
      apb(1'b1, 8'h04, 32'h0000_0020);
      send(5'h00, 1'b0, 1'b1);
      check("irq_done", 32'h1, 32'(irq));
      apb(1'b0, 8'h00, 32'h0);
      check("status_done", 32'h2, rd);
      apb(1'b0, 8'h4C, 32'h0);
      check("data", 32'h0000_1234, rd);
      check("irq_after_data", 32'h0, 32'(irq));
      apb(1'b1, 8'h04, 32'h0);
      send(5'h00, 1'b0, 1'b1);
      check("irq_done_off", 32'h0, 32'(irq));
   endtask : t_done

   task automatic t_burst;
      apb(1'b1, 8'h04, 32'h0000_4800);
      check("hold_idle", 32'h1, 32'(seq_hold));
      @(posedge pclk);
      trigger <= 1'b1;
      @(posedge pclk);
      trigger <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         send(5'h02, 1'b0, 1'b0);
         check("hold_burst", 32'(i == 2), 32'(seq_hold));
      end
   endtask : t_burst

   initial begin
      {presetn, psel, penable, pwrite, trigger} = '0;
      paddr = 32'h0;
      pwdata = 32'h0;
      sample = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_fields();
      t_watchdog();
      t_done();
      t_burst();
      wrap_up();
   end
endmodule : test_adc_control_register_zero
